// *** cmd_data_path.sv ***
// Core memory word data path with cycle sequencer and AXI4-Lite control
//
// How it works
// - Read half-select erases cores; ones give pulses
// - Sense output needs pulse and sense strobe
// - Register cleared three cycles before sense strobe
// - Sense output presets its register bit
// - Output enable pulls bus low for ones
// - Every read followed at once by restore
// - One bit keeps inhibit off, writes one
// - Zero bit turns inhibit on, writes zero
// - Master's bus word loaded at write start
// - Receivers invert active-low bus lines
// - Write-only cycle suppresses clear and strobe
// - Y read current starts before X
// - Slice replicated for every data bit
// - Clear split into low and high byte
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
module cmd_data_path #(
    parameter int DATA_W      = cmd_pkg::DATA_W,
    parameter int WORD_ADDR_W = cmd_pkg::WORD_ADDR_W
) (
    // Clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // AXI4-Lite write address
    input  wire logic [cmd_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [cmd_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // System bus data lines, active low, open drain
    input  wire logic [DATA_W-1:0]          bus_d_in_n,
    output logic      [DATA_W-1:0]          bus_d_out_n,
    output logic      [DATA_W-1:0]          bus_d_oe_n,
    // Cycle strobes
    output logic                            low_byte_clear_n,
    output logic                            high_byte_clear_n,
    output logic                            sense_strobe,
    output logic                            bus_drive_enable,
    output logic                            data_reg_load_clk,
    output logic                            inhibit_time_n,
    // Drive currents and inhibit drivers
    output logic                            y_read_on,
    output logic                            x_read_on,
    output logic                            write_on,
    output logic      [DATA_W-1:0]          inhibit_on,
    // Status
    output logic                            cycle_busy,
    output logic      [DATA_W-1:0]          word_data_register
);
    import cmd_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        cmd_state_e             state;
        logic                   cyc_write;
        logic [WORD_ADDR_W-1:0] cyc_addr;
        logic                   mode_write;
        logic [WORD_ADDR_W-1:0] addr;
        logic                   done;
        logic [COUNT_W-1:0]     count;
        logic                   aw_held;
        logic [AXI_AW-1:0]      aw_addr;
        logic                   w_held;
        logic [31:0]            w_data;
        logic [3:0]             w_strb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } cmd_top_s;

    cmd_top_s st_reg;
    cmd_top_s st_next;

    logic [DATA_W-1:0] core_pulse;
    logic [DATA_W-1:0] core_wdata;
    logic [DATA_W-1:0] reg_q;
    logic              clear_lo_n;
    logic              clear_hi_n;

    // ------------------------------------------------------------------
    // Strobes decoded from the one-hot state
    // ------------------------------------------------------------------
    // Clear and sense never occur in a write-only cycle: CLEAR is not
    // entered and the strobe is gated off in SENSE, so the loaded word survives the erase
    assign clear_lo_n        = (st_reg.state != S_CLEAR);
    assign clear_hi_n        = (st_reg.state != S_CLEAR);
    assign sense_strobe      = (st_reg.state == S_SENSE) && !st_reg.cyc_write;
    assign bus_drive_enable  = (st_reg.state == S_DRIVE);
    assign data_reg_load_clk = (st_reg.state == S_LOAD);
    assign inhibit_time_n    = (st_reg.state != S_WRITE);
    assign y_read_on         = (st_reg.state == S_YREAD)
                             || (st_reg.state == S_XREAD);
    assign x_read_on         = (st_reg.state == S_XREAD);
    assign write_on          = (st_reg.state == S_WRITE);
    assign cycle_busy        = (st_reg.state != S_IDLE);
    assign low_byte_clear_n  = clear_lo_n;
    assign high_byte_clear_n = clear_hi_n;

    // ------------------------------------------------------------------
    // Per-bit slices
    // ------------------------------------------------------------------
    for (genvar i = 0; i < DATA_W; i++) begin : g_bit
        cmd_bit_slice u_slice (
            .aclk              (aclk),
            .aresetn           (aresetn),
            .core_pulse        (core_pulse[i]),
            .sense_strobe      (sense_strobe),
            .clear_n           ((i < DATA_W/2) ? clear_lo_n : clear_hi_n),
            .data_reg_load_clk (data_reg_load_clk),
            .bus_in_n          (bus_d_in_n[i]),
            .bus_drive_enable  (bus_drive_enable),
            .bus_out_n         (bus_d_out_n[i]),
            .bus_oe_n          (bus_d_oe_n[i]),
            .inhibit_time_n    (inhibit_time_n),
            .inhibit_on        (inhibit_on[i]),
            .bit_q             (reg_q[i])
        );
    end

    // A core receives a one wherever no inhibit current opposes drive
    assign core_wdata         = ~inhibit_on;
    assign word_data_register = reg_q;

    // ------------------------------------------------------------------
    // Core stack
    // ------------------------------------------------------------------
    cmd_core_array #(
        .AW (WORD_ADDR_W),
        .DW (DATA_W)
    ) u_cores (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .erase_en (x_read_on),
        .write_en (write_on),
        .addr     (st_reg.cyc_addr),
        .wdata    (core_wdata),
        .pulse    (core_pulse)
    );

    // ------------------------------------------------------------------
    // AXI4-Lite handshakes
    // ------------------------------------------------------------------
    assign s_axi_awready = !st_reg.aw_held && !st_reg.bvalid;
    assign s_axi_wready  = !st_reg.w_held && !st_reg.bvalid;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic start;
        start   = 1'b0;
        st_next = st_reg;

        // Write channel: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_held = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_held = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
            st_next.aw_held = 1'b0;
            st_next.w_held  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = RESP_OKAY;
            unique case (st_reg.aw_addr)
                REG_CTRL: begin
                    if (st_reg.w_strb[0]) begin
                        st_next.mode_write = st_reg.w_data[CTRL_WRITE_BIT];
                        // A start while a cycle runs is dropped
                        start = st_reg.w_data[CTRL_START_BIT]
                              && (st_reg.state == S_IDLE);
                    end
                end
                REG_ADDR: begin
                    if (st_reg.w_strb[0]) begin
                        st_next.addr[7:0] = st_reg.w_data[7:0];
                    end
                    if (st_reg.w_strb[1]) begin
                        st_next.addr[WORD_ADDR_W-1:8] =
                            st_reg.w_data[WORD_ADDR_W-1:8];
                    end
                end
                REG_STATUS, REG_DATA, REG_COUNT: begin
                end
                default: begin
                    st_next.bresp = RESP_SLVERR;
                end
            endcase
        end

        // Read channel
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = RESP_OKAY;
            st_next.rdata  = 32'h0000_0000;
            unique case (s_axi_araddr)
                REG_CTRL: begin
                    st_next.rdata[CTRL_WRITE_BIT] = st_reg.mode_write;
                end
                REG_ADDR: begin
                    st_next.rdata[WORD_ADDR_W-1:0] = st_reg.addr;
                end
                REG_STATUS: begin
                    st_next.rdata[STATUS_BUSY_BIT] = cycle_busy;
                    st_next.rdata[STATUS_DONE_BIT] = st_reg.done;
                    st_next.rdata[STATUS_MODE_BIT] = st_reg.cyc_write;
                end
                REG_DATA: begin
                    st_next.rdata[DATA_W-1:0] = reg_q;
                end
                REG_COUNT: begin
                    st_next.rdata[COUNT_W-1:0] = st_reg.count;
                end
                default: begin
                    st_next.rresp = RESP_SLVERR;
                end
            endcase
        end

        // Memory cycle sequencer; the register is touched only in
        // LOAD, CLEAR and SENSE, so it holds through the write phase
        unique case (st_reg.state)
            S_IDLE: begin
                if (start) begin
                    st_next.cyc_write = st_reg.w_data[CTRL_WRITE_BIT];
                    st_next.cyc_addr  = st_reg.addr;
                    st_next.done      = 1'b0;
                    st_next.state     = st_reg.w_data[CTRL_WRITE_BIT]
                                      ? S_LOAD : S_CLEAR;
                end
            end
            S_LOAD: begin
                st_next.state = S_YREAD;
            end
            S_CLEAR: begin
                st_next.state = S_YREAD;
            end
            S_YREAD: begin
                st_next.state = S_XREAD;
            end
            S_XREAD: begin
                st_next.state = S_SENSE;
            end
            S_SENSE: begin
                st_next.state = st_reg.cyc_write ? S_WRITE : S_DRIVE;
            end
            S_DRIVE: begin
                st_next.state = S_WRITE;
            end
            S_WRITE: begin
                st_next.state = S_IDLE;
                st_next.done  = 1'b1;
                st_next.count = st_reg.count + 16'h0001;
            end
            default: begin
                st_next.state = S_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg            <= '0;
            st_reg.state      <= S_IDLE;
            st_reg.mode_write <= MODE_RST;
            st_reg.addr       <= ADDR_RST;
            st_reg.count      <= COUNT_RST;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule // cmd_data_path

// *** cmd_pkg.sv ***
// Shared constants and types for the core memory word data path
package cmd_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DATA_W      = 16;
    localparam int WORD_ADDR_W = 14;
    localparam int AXI_AW      = 8;
    localparam int COUNT_W     = 16;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [AXI_AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [AXI_AW-1:0] REG_ADDR   = 8'h04;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;
    localparam logic [AXI_AW-1:0] REG_DATA   = 8'h0c;
    localparam logic [AXI_AW-1:0] REG_COUNT  = 8'h10;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_WRITE_BIT  = 1;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_DONE_BIT = 1;
    localparam int STATUS_MODE_BIT = 2;

    localparam logic                   MODE_RST  = 1'b0;
    localparam logic [WORD_ADDR_W-1:0] ADDR_RST  = 14'h0000;
    localparam logic [COUNT_W-1:0]     COUNT_RST = 16'h0000;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------------
    // Memory cycle sequencer states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [7:0] {
        S_IDLE  = 8'h01,
        S_LOAD  = 8'h02,
        S_CLEAR = 8'h04,
        S_YREAD = 8'h08,
        S_XREAD = 8'h10,
        S_SENSE = 8'h20,
        S_DRIVE = 8'h40,
        S_WRITE = 8'h80
    } cmd_state_e;

endpackage

// *** cmd_core_array.sv ***
// Core stack model: destructive read-out and inhibit-gated write-back
`timescale 1ns/1ns
module cmd_core_array #(
    parameter int AW = cmd_pkg::WORD_ADDR_W,
    parameter int DW = cmd_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // Drive currents
    input  wire logic          erase_en,
    input  wire logic          write_en,
    input  wire logic [AW-1:0] addr,
    // Per bit: 1 where no inhibit current flows
    input  wire logic [DW-1:0] wdata,
    // Switching pulses of the last read
    output logic      [DW-1:0] pulse
);
    import cmd_pkg::*;

    logic [DW-1:0] cores [0:(1<<AW)-1];
    logic [DW-1:0] pulse_reg;

    // Half-select read drives every addressed core to zero; only
    // cores that held a one switch and give a pulse
    always_ff @(posedge aclk) begin
        if (erase_en) begin
            cores[addr] <= '0;
        end else if (write_en) begin
            cores[addr] <= wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse_reg <= '0;
        end else if (erase_en) begin
            pulse_reg <= cores[addr];
        end else begin
            pulse_reg <= '0;
        end
    end

    assign pulse = pulse_reg;

endmodule // cmd_core_array

// *** cmd_bit_slice.sv ***
// One data bit: sense channel, register bit, bus driver/receiver, inhibit
`timescale 1ns/1ns
module cmd_bit_slice (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Sense channel
    input  wire logic core_pulse,
    input  wire logic sense_strobe,
    // Register control strobes
    input  wire logic clear_n,
    input  wire logic data_reg_load_clk,
    // System bus line
    input  wire logic bus_in_n,
    input  wire logic bus_drive_enable,
    output logic      bus_out_n,
    output logic      bus_oe_n,
    // Inhibit
    input  wire logic inhibit_time_n,
    output logic      inhibit_on,
    output logic      bit_q
);
    import cmd_pkg::*;

    typedef struct packed {
        logic q;
    } cmd_slice_s;

    cmd_slice_s st_reg;
    cmd_slice_s st_next;
    logic       sense_out;

    // Pulse above threshold counts only while strobed
    assign sense_out = core_pulse & sense_strobe;

    always_comb begin
        st_next = st_reg;
        if (sense_out) begin
            st_next.q = 1'b1;
        end else if (!clear_n) begin
            st_next.q = 1'b0;
        end else if (data_reg_load_clk) begin
            st_next.q = ~bus_in_n;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Open-drain: pull low for a one, release for a zero
    assign bus_out_n  = 1'b0;
    assign bus_oe_n   = ~(bus_drive_enable & st_reg.q);
    assign inhibit_on = ~inhibit_time_n & ~st_reg.q;
    assign bit_q      = st_reg.q;

endmodule // cmd_bit_slice

// *** cmd_data_path_asserts.sv ***
// Concurrent checks on the word data path strobes, bus lines and inhibit drivers
`timescale 1ns/1ns
module cmd_data_path_asserts (
    // Clock and reset
    input logic                        aclk,
    input logic                        aresetn,
    // System bus lines
    input logic [cmd_pkg::DATA_W-1:0]  bus_d_in_n,
    input logic [cmd_pkg::DATA_W-1:0]  bus_d_oe_n,
    // Cycle strobes
    input logic                        low_byte_clear_n,
    input logic                        high_byte_clear_n,
    input logic                        sense_strobe,
    input logic                        bus_drive_enable,
    input logic                        data_reg_load_clk,
    input logic                        inhibit_time_n,
    // Drive currents and register
    input logic                        y_read_on,
    input logic                        x_read_on,
    input logic                        write_on,
    input logic [cmd_pkg::DATA_W-1:0]  inhibit_on,
    input logic [cmd_pkg::DATA_W-1:0]  word_data_register
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_clear_then_sense: assert property (sense_strobe |-> !$past(low_byte_clear_n, 3))
        else $error("sense strobe without clear three cycles earlier");
    a_byte_clears: assert property (low_byte_clear_n == high_byte_clear_n)
        else $error("byte clears disagree");
    a_sense_after_read: assert property (sense_strobe |-> $past(x_read_on))
        else $error("sense strobe not right after x read");
    a_bus_readout: assert property (bus_d_oe_n == (bus_drive_enable ? ~word_data_register
        : '1))
        else $error("bus drivers disagree with register");
    a_inhibit_map: assert property (inhibit_on == (inhibit_time_n ? '0
        : ~word_data_register))
        else $error("inhibit drivers disagree with register");
    a_restore_next: assert property (sense_strobe |=> bus_drive_enable ##1
        (!inhibit_time_n && write_on))
        else $error("restore write did not follow read");
    a_y_before_x: assert property (x_read_on |-> y_read_on && $past(y_read_on)
        && !$past(x_read_on))
        else $error("x read current not preceded by y");
    a_write_only_quiet: assert property (data_reg_load_clk |=>
        (low_byte_clear_n && !sense_strobe && !bus_drive_enable)[*4] ##0 !inhibit_time_n)
        else $error("clear or sense in write-only cycle");
    a_load_inverts: assert property (data_reg_load_clk |=>
        word_data_register == ~$past(bus_d_in_n))
        else $error("register load does not invert bus");
    a_reg_hold: assert property (!inhibit_time_n |-> $stable(word_data_register) ##1
        $stable(word_data_register))
        else $error("register moved around write");
endmodule // cmd_data_path_asserts

bind cmd_data_path cmd_data_path_asserts cmd_data_path_asserts_inst (
    .aclk(aclk), .aresetn(aresetn), .bus_d_in_n(bus_d_in_n), .bus_d_oe_n(bus_d_oe_n),
    .low_byte_clear_n(low_byte_clear_n), .high_byte_clear_n(high_byte_clear_n),
    .sense_strobe(sense_strobe), .bus_drive_enable(bus_drive_enable),
    .data_reg_load_clk(data_reg_load_clk), .inhibit_time_n(inhibit_time_n),
    .y_read_on(y_read_on), .x_read_on(x_read_on), .write_on(write_on),
    .inhibit_on(inhibit_on), .word_data_register(word_data_register)
);

// *** cmd_bus_master.sv ***
// Requesting bus master: drives write words, samples read words off the lines
`timescale 1ns/1ns
module cmd_bus_master (
    // Clock
    input  logic        aclk,
    // Request side
    input  logic        drive,
    input  logic [15:0] word,
    // Device drivers
    input  logic [15:0] dev_out_n,
    input  logic [15:0] dev_oe_n,
    input  logic        bus_drive_enable,
    // Resolved lines and captured readout
    output logic [15:0] line_n,
    output logic [15:0] seen
);
    // Pull-ups hold released lines high; either party may pull a line low
    assign line_n = ~(drive ? word : 16'h0000) & (dev_oe_n | dev_out_n);

    always_ff @(posedge aclk) begin
        if (bus_drive_enable)
            seen <= ~line_n;
    end
endmodule // cmd_bus_master

// *** core_memory_bit_data_path_test.sv ***
// Self-checking bench for the core memory word data path
`timescale 1ns/1ns
module core_memory_bit_data_path_test;
    import cmd_pkg::*;
    logic        aclk = 0;
    logic        aresetn = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [15:0] din_n, dout_n, doe_n, inh, wdr, pword = 0, seen;
    logic        pdrive = 0;
    logic        lbc_n, hbc_n, sstb, bde, ldclk, itn, yon, xon, won, busy;
    int          error_cnt = 0, comparisons = 0, count_m = 0;
    logic [15:0] mem [0:16383];

    always #50 aclk = ~aclk;

    cmd_data_path cmd_data_path_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .bus_d_in_n(din_n), .bus_d_out_n(dout_n),
        .bus_d_oe_n(doe_n), .low_byte_clear_n(lbc_n), .high_byte_clear_n(hbc_n),
        .sense_strobe(sstb), .bus_drive_enable(bde), .data_reg_load_clk(ldclk),
        .inhibit_time_n(itn), .y_read_on(yon), .x_read_on(xon), .write_on(won),
        .inhibit_on(inh), .cycle_busy(busy), .word_data_register(wdr)
    );

    cmd_bus_master cmd_bus_master_inst (
        .aclk(aclk), .drive(pdrive), .word(pword), .dev_out_n(dout_n),
        .dev_oe_n(doe_n), .bus_drive_enable(bde), .line_n(din_n), .seen(seen)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (awready)
                awvalid <= 0;
            if (wready)
                wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        r = bresp;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            if (arready)
                arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        d = rdata;
        r = rresp;
    endtask

    // One memory cycle, checked against the word model
    task automatic mem_cycle(input logic [13:0] a, input logic wr, input logic [15:0] w,
                             input logic drv);
        logic [1:0]  r;
        logic [31:0] d;
        logic [15:0] exp;
        pword <= w;
        pdrive <= drv;
        axi_wr(REG_ADDR, {18'h0, a}, r);
        axi_wr(REG_CTRL, {30'h0, wr, 1'b1}, r);
        chk(r, RESP_OKAY, "ctrl resp");
        do @(posedge aclk); while (busy);
        pdrive <= 0;
        exp = wr ? (drv ? w : 16'h0000) : mem[a];
        if (!wr)
            chk(seen, exp, "bus readout");
        mem[a] = exp;
        count_m++;
        axi_rd(REG_DATA, d, r);
        chk(d, {16'h0, exp}, "data register");
        axi_rd(REG_ADDR, d, r);
        chk(d, {18'h0, a}, "address");
        axi_rd(REG_CTRL, d, r);
        chk(d, {30'h0, wr, 1'b0}, "ctrl mode");
        axi_rd(REG_STATUS, d, r);
        chk(d, {29'h0, wr, 2'b10}, "status");
        axi_rd(REG_COUNT, d, r);
        chk(d, count_m, "count");
    endtask

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [13:0] a;
        logic [15:0] w;
        void'($urandom(32'h2de21eb6));
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        axi_rd(REG_DATA, d, r);
        chk(d, 32'h0, "reset data");
        axi_wr(REG_DATA, 32'hffff, r);
        chk(r, RESP_OKAY, "read-only write resp");
        axi_rd(REG_DATA, d, r);
        chk(d, 32'h0, "read-only write ignored");
        axi_rd(8'h20, d, r);
        chk(r, RESP_SLVERR, "unmapped read");
        axi_wr(8'h20, 32'h1, r);
        chk(r, RESP_SLVERR, "unmapped write");
        // Released lines float high, so an undriven write stores zeros
        mem_cycle(14'h0009, 1, 16'hffff, 0);
        mem_cycle(14'h0005, 1, 16'hffff, 1);
        mem_cycle(14'h0009, 0, 16'h0, 0);
        mem_cycle(14'h0005, 0, 16'h0, 0);
        mem_cycle(14'h0005, 1, 16'ha5a5, 1);
        mem_cycle(14'h0005, 0, 16'h0, 0);
        mem_cycle(14'h0009, 0, 16'h0, 0);
        for (int i = 0; i < 6; i++) begin
            a = 14'($urandom);
            w = 16'($urandom);
            mem_cycle(a, 1, w, 1);
            mem_cycle(a, 0, 16'h0, 0);
            mem_cycle(a, 0, 16'h0, 0);
        end
        stop_test();
    end

    initial begin
        #(6000 * 100);
        error_cnt++;
        $display("MISMATCH %0t watchdog expired", $time);
        stop_test();
    end
endmodule // core_memory_bit_data_path_test
